// file: rtl/fgl_cfg.svh
`ifndef FGL_CFG_SVH
`define FGL_CFG_SVH

`define FGL_PTR_W        15
`define FGL_CNT_W        7
`define FGL_LVL_W        3
`define FGL_ADR_W        14
`define FGL_ADR_HI       13
`define FGL_ADR_LO       2
`define FGL_IDX_W        12

`define FGL_IDX_HEAD_LO  12'hec1
`define FGL_IDX_HEAD_HI  12'hec2
`define FGL_IDX_TAIL_LO  12'hec3
`define FGL_IDX_TAIL_HI  12'hec4
`define FGL_IDX_NUM_LO   12'hec5
`define FGL_IDX_NUM_HI   12'hec6
`define FGL_IDX_POP      12'hec7
`define FGL_IDX_INFO0    12'hec8
`define FGL_IDX_INFO1    12'hec9
`define FGL_IDX_INFO2    12'heca
`define FGL_IDX_INFO3    12'hecb
`define FGL_IDX_INFO4    12'hecc
`define FGL_IDX_INFO5    12'hecd

`define FGL_STB_BIT      7
`define FGL_POP_BIT      0
`define FGL_BYTE_SEL     0
`define FGL_LVL_LSB      5
`define FGL_QM_BIT       4
`define FGL_MC_BIT       5
`define FGL_LVL_EMPTY    3'h0
`define FGL_ZERO_BYTE    8'h00
`define FGL_ZERO_PTR     15'h0000
`define FGL_ZERO_CNT     7'h00
`define FGL_RD_PAD       24'h000000

`endif

// file: rtl/fgl_pkg.sv
`include "fgl_cfg.svh"

package fgl_pkg;

    // one release fifo entry as the buffer manager presents it
    typedef struct packed {
        logic [`FGL_PTR_W-1:0] head;
        logic [`FGL_PTR_W-1:0] tail;
        logic [`FGL_CNT_W-1:0] cnt;
        logic                  mcast;
        logic [3:0]            src;
        logic [1:0]            cls;
        logic                  qm;
    } fgl_rls_t;

    typedef struct packed {
        logic                  ack;
        logic [7:0]            rdat;
        logic [7:0]            head_lo;
        logic [7:0]            head_hi;
        logic [7:0]            tail_lo;
        logic [7:0]            tail_hi;
        logic [7:0]            num_lo;
        logic [7:0]            num_hi;
        logic                  pop_bit;
        fgl_rls_t              info;
        logic [`FGL_PTR_W-1:0] head;
        logic [`FGL_PTR_W-1:0] tail;
        logic [`FGL_PTR_W-1:0] num;
        logic                  head_ld;
        logic                  tail_ld;
        logic                  num_ld;
        logic                  build;
        logic                  pop;
    } fgl_state_t;

endpackage

// file: rtl/fgl_regs.sv
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "fgl_cfg.svh"

module fgl_regs
    import fgl_pkg::*;
(
    input  wire logic                  SYS_CLK_IN,
    input  wire logic                  SRST_IN,
    input  wire logic                  WB_CYC_IN,
    input  wire logic                  WB_STB_IN,
    input  wire logic                  WB_WE_IN,
    input  wire logic [`FGL_ADR_W-1:0] WB_ADR_IN,
    input  wire logic [3:0]            WB_SEL_IN,
    input  wire logic [31:0]           WB_DAT_IN,
    output logic      [31:0]           WB_DAT_OUT,
    output logic                       WB_ACK_OUT,
    input  wire fgl_rls_t              RLS_ENTRY_IN,
    input  wire logic [`FGL_LVL_W-1:0] RLS_LEVEL_IN,
    output logic                       RLS_POP_OUT,
    output logic      [`FGL_PTR_W-1:0] FREE_HEAD_OUT,
    output logic      [`FGL_PTR_W-1:0] FREE_TAIL_OUT,
    output logic      [`FGL_PTR_W-1:0] FREE_NUM_OUT,
    output logic                       HEAD_LOAD_OUT,
    output logic                       TAIL_LOAD_OUT,
    output logic                       NUM_LOAD_OUT,
    output logic                       BUILD_CHAIN_OUT
);

////////////////////////////////////////////////////////////////////////////////

    fgl_state_t            s_r;
    fgl_state_t            s_nxt;
    logic [`FGL_IDX_W-1:0] idx;
    logic [7:0]            wdat;
    logic                  req;
    logic                  wr;

    function automatic logic fgl_rise(input logic [7:0] old_b,
                                      input logic [7:0] new_b);
        fgl_rise = !old_b[`FGL_STB_BIT] && new_b[`FGL_STB_BIT];
    endfunction

    function automatic logic [`FGL_PTR_W-1:0] fgl_join(input logic [7:0] hi,
                                                       input logic [7:0] lo);
        fgl_join = {hi[`FGL_STB_BIT-1:0], lo};
    endfunction

    assign idx  = WB_ADR_IN[`FGL_ADR_HI:`FGL_ADR_LO];
    assign wdat = WB_DAT_IN[7:0];
    assign req  = WB_CYC_IN && WB_STB_IN && !s_r.ack;
    // writes land on the edge where the master samples ack
    assign wr   = WB_CYC_IN && WB_STB_IN && WB_WE_IN && s_r.ack
                  && WB_SEL_IN[`FGL_BYTE_SEL];

////////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        s_nxt         = s_r;
        s_nxt.ack     = req;
        s_nxt.head_ld = 1'b0;
        s_nxt.tail_ld = 1'b0;
        s_nxt.num_ld  = 1'b0;
        s_nxt.build   = 1'b0;
        s_nxt.pop     = 1'b0;

        // read data is taken when ack rises; unmapped reads give zero
        if (req)
        begin
            if (idx == `FGL_IDX_HEAD_LO)
                s_nxt.rdat = s_r.head_lo;
            else if (idx == `FGL_IDX_HEAD_HI)
                s_nxt.rdat = s_r.head_hi;
            else if (idx == `FGL_IDX_TAIL_LO)
                s_nxt.rdat = s_r.tail_lo;
            else if (idx == `FGL_IDX_TAIL_HI)
                s_nxt.rdat = s_r.tail_hi;
            else if (idx == `FGL_IDX_NUM_LO)
                s_nxt.rdat = s_r.num_lo;
            else if (idx == `FGL_IDX_NUM_HI)
                s_nxt.rdat = s_r.num_hi;
            else if (idx == `FGL_IDX_POP)
                s_nxt.rdat = {7'h00, s_r.pop_bit};
            else if (idx == `FGL_IDX_INFO0)
                s_nxt.rdat = s_r.info.head[7:0];
            else if (idx == `FGL_IDX_INFO1)
                s_nxt.rdat = {s_r.info.tail[0], s_r.info.head[14:8]};
            else if (idx == `FGL_IDX_INFO2)
                s_nxt.rdat = s_r.info.tail[8:1];
            else if (idx == `FGL_IDX_INFO3)
                s_nxt.rdat = {s_r.info.cnt[1:0], s_r.info.tail[14:9]};
            else if (idx == `FGL_IDX_INFO4)
                s_nxt.rdat = {s_r.info.src[1:0], s_r.info.mcast,
                              s_r.info.cnt[6:2]};
            else if (idx == `FGL_IDX_INFO5)
                // level is live so software can poll for new entries
                s_nxt.rdat = {RLS_LEVEL_IN, s_r.info.qm, s_r.info.cls,
                              s_r.info.src[3:2]};
            else
                s_nxt.rdat = `FGL_ZERO_BYTE;
        end

        if (wr)
        begin
            if (idx == `FGL_IDX_HEAD_LO)
                s_nxt.head_lo = wdat;
            else if (idx == `FGL_IDX_HEAD_HI)
            begin
                s_nxt.head_hi = wdat;
                if (fgl_rise(s_r.head_hi, wdat))
                begin
                    s_nxt.head    = fgl_join(wdat, s_r.head_lo);
                    s_nxt.head_ld = 1'b1;
                end
            end
            else if (idx == `FGL_IDX_TAIL_LO)
                s_nxt.tail_lo = wdat;
            else if (idx == `FGL_IDX_TAIL_HI)
            begin
                s_nxt.tail_hi = wdat;
                if (fgl_rise(s_r.tail_hi, wdat))
                begin
                    s_nxt.tail    = fgl_join(wdat, s_r.tail_lo);
                    s_nxt.tail_ld = 1'b1;
                end
            end
            else if (idx == `FGL_IDX_NUM_LO)
                s_nxt.num_lo = wdat;
            else if (idx == `FGL_IDX_NUM_HI)
            begin
                s_nxt.num_hi = wdat;
                if (fgl_rise(s_r.num_hi, wdat))
                begin
                    s_nxt.num    = fgl_join(wdat, s_r.num_lo);
                    s_nxt.num_ld = 1'b1;
                    // committed head and tail both zero select chain build;
                    // the count must come last for either mode
                    s_nxt.build  = (s_r.head == `FGL_ZERO_PTR) &&
                                   (s_r.tail == `FGL_ZERO_PTR);
                end
            end
            else if (idx == `FGL_IDX_POP)
            begin
                s_nxt.pop_bit = wdat[`FGL_POP_BIT];
                // an empty fifo is never popped, the info bytes keep old data
                if (!s_r.pop_bit && wdat[`FGL_POP_BIT] &&
                    RLS_LEVEL_IN != `FGL_LVL_EMPTY)
                begin
                    s_nxt.pop  = 1'b1;
                    s_nxt.info = RLS_ENTRY_IN;
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (SRST_IN)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

////////////////////////////////////////////////////////////////////////////////

    assign WB_DAT_OUT      = {`FGL_RD_PAD, s_r.rdat};
    assign WB_ACK_OUT      = s_r.ack;
    assign RLS_POP_OUT     = s_r.pop;
    assign FREE_HEAD_OUT   = s_r.head;
    assign FREE_TAIL_OUT   = s_r.tail;
    assign FREE_NUM_OUT    = s_r.num;
    assign HEAD_LOAD_OUT   = s_r.head_ld;
    assign TAIL_LOAD_OUT   = s_r.tail_ld;
    assign NUM_LOAD_OUT    = s_r.num_ld;
    assign BUILD_CHAIN_OUT = s_r.build;

////////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (SRST_IN);

    sequence wr_to(logic [`FGL_IDX_W-1:0] a);
        wr && idx == a;
    endsequence

    chk_tail_commit: assert property (
        wr_to(`FGL_IDX_TAIL_HI) ##0 (!s_r.tail_hi[7] && wdat[7])
        |=> TAIL_LOAD_OUT &&
            FREE_TAIL_OUT == {$past(wdat[6:0]), $past(s_r.tail_lo)})
        else $error("tail pointer not committed on strobe rise");

    chk_tail_stage: assert property (
        !TAIL_LOAD_OUT |-> $stable(FREE_TAIL_OUT))
        else $error("tail pointer changed without commit");

    chk_count_commit: assert property (
        wr_to(`FGL_IDX_NUM_HI) ##0 (!s_r.num_hi[7] && wdat[7])
        |=> NUM_LOAD_OUT &&
            FREE_NUM_OUT == {$past(wdat[6:0]), $past(s_r.num_lo)})
        else $error("granule count not committed on strobe rise");

    chk_count_hold: assert property (
        wr_to(`FGL_IDX_NUM_HI) ##0 s_r.num_hi[7] |=> !NUM_LOAD_OUT)
        else $error("count committed with strobe held high");

    chk_head_commit: assert property (
        HEAD_LOAD_OUT |-> $past(wr && idx == `FGL_IDX_HEAD_HI) &&
            !$past(s_r.head_hi[7]) && s_r.head_hi[7])
        else $error("head commit without strobe rise");

    chk_build_mode: assert property (
        BUILD_CHAIN_OUT |-> NUM_LOAD_OUT &&
            $past(FREE_HEAD_OUT) == `FGL_ZERO_PTR &&
            $past(FREE_TAIL_OUT) == `FGL_ZERO_PTR)
        else $error("chain build without cleared pointers");

    chk_pop_edge: assert property (
        RLS_POP_OUT |-> $past(wr && idx == `FGL_IDX_POP) &&
            !$past(s_r.pop_bit) ##1 !RLS_POP_OUT)
        else $error("pop without a 0 to 1 change");

    chk_pop_latch: assert property (
        RLS_POP_OUT |-> s_r.info == $past(RLS_ENTRY_IN) &&
            $past(RLS_LEVEL_IN) != `FGL_LVL_EMPTY)
        else $error("pop did not latch a valid entry");

    chk_level_read: assert property (
        req && idx == `FGL_IDX_INFO5 |=> WB_ACK_OUT &&
            WB_DAT_OUT[7:5] == $past(RLS_LEVEL_IN) &&
            WB_DAT_OUT[4] == s_r.info.qm)
        else $error("fifo level or manager flag misread");

    chk_mcast_read: assert property (
        req && idx == `FGL_IDX_INFO4 |=> WB_DAT_OUT[5] == s_r.info.mcast &&
            WB_DAT_OUT[4:0] == s_r.info.cnt[6:2])
        else $error("multicast flag misread");

    chk_head_value: assert property (
        wr_to(`FGL_IDX_HEAD_HI) ##0 (!s_r.head_hi[7] && wdat[7])
        |=> HEAD_LOAD_OUT &&
            FREE_HEAD_OUT == {$past(wdat[6:0]), $past(s_r.head_lo)})
        else $error("head pointer not committed on strobe rise");

    chk_head_stage: assert property (
        !HEAD_LOAD_OUT |-> $stable(FREE_HEAD_OUT))
        else $error("head pointer changed without commit");

    chk_count_stage: assert property (
        !NUM_LOAD_OUT |-> $stable(FREE_NUM_OUT))
        else $error("granule count changed without commit");

    chk_tail_hold: assert property (
        wr_to(`FGL_IDX_TAIL_HI) ##0 s_r.tail_hi[7] |=> !TAIL_LOAD_OUT)
        else $error("tail committed with strobe held high");

    chk_build_pick: assert property (
        wr_to(`FGL_IDX_NUM_HI) ##0 (!s_r.num_hi[7] && wdat[7] &&
            FREE_HEAD_OUT == `FGL_ZERO_PTR && FREE_TAIL_OUT == `FGL_ZERO_PTR)
        |=> BUILD_CHAIN_OUT)
        else $error("chain build missed with cleared pointers");

    chk_pop_fires: assert property (
        wr_to(`FGL_IDX_POP) ##0 (!s_r.pop_bit && wdat[`FGL_POP_BIT] &&
            RLS_LEVEL_IN != `FGL_LVL_EMPTY)
        |=> RLS_POP_OUT)
        else $error("pop missed on a 0 to 1 change");

    chk_pop_hold: assert property (
        wr_to(`FGL_IDX_POP) ##0 s_r.pop_bit |=> !RLS_POP_OUT)
        else $error("pop with the request bit held high");

    chk_pop_empty: assert property (
        wr_to(`FGL_IDX_POP) ##0 (RLS_LEVEL_IN == `FGL_LVL_EMPTY)
        |=> !RLS_POP_OUT)
        else $error("pop of an empty fifo");

    chk_info_hold: assert property (
        !RLS_POP_OUT |-> $stable(s_r.info))
        else $error("info bytes changed without a pop");

    chk_info_head: assert property (
        req && idx == `FGL_IDX_INFO0 |=>
            WB_DAT_OUT[7:0] == s_r.info.head[7:0])
        else $error("released head pointer misread");

endmodule // fgl_regs

`default_nettype wire

// file: verif/fgl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fgl_cfg.svh"

module testbench
    import fgl_pkg::*;
;
    logic                  clk  = 1'b0;
    logic                  srst = 1'b1;
    logic                  cyc  = 1'b0;
    logic                  stb  = 1'b0;
    logic                  we   = 1'b0;
    logic [`FGL_ADR_W-1:0] adr  = '0;
    logic [31:0]           wdat = '0;
    fgl_rls_t              ent  = '0;
    logic [`FGL_LVL_W-1:0] lvl  = '0;
    logic [3:0]            sel  = 4'h1;
    logic [31:0]           rdat;
    logic [31:0]           q_rd;
    logic                  ack, pop, hld, tld, nld, bld;
    logic [`FGL_PTR_W-1:0] head, tail, num;
    int                    num_errors = 0;
    int                    n_tests = 0;
    int                    cyc_cnt = 0;
    int                    c_h = 0, c_t = 0, c_n = 0, c_b = 0, c_p = 0;
    fgl_rls_t              e1 = '{15'h2a5c, 15'h4b31, 7'h5d, 1'b1,
                                  4'h9, 2'h2, 1'b1};
    fgl_rls_t              e2 = '{15'h0001, 15'h7fff, 7'h03, 1'b0,
                                  4'h6, 2'h1, 1'b0};

    // only byte lane 0 carries data; one write drops it to prove it is ignored
    fgl_regs i_dut (
        .SYS_CLK_IN      (clk),
        .SRST_IN         (srst),
        .WB_CYC_IN       (cyc),
        .WB_STB_IN       (stb),
        .WB_WE_IN        (we),
        .WB_ADR_IN       (adr),
        .WB_SEL_IN       (sel),
        .WB_DAT_IN       (wdat),
        .WB_DAT_OUT      (rdat),
        .WB_ACK_OUT      (ack),
        .RLS_ENTRY_IN    (ent),
        .RLS_LEVEL_IN    (lvl),
        .RLS_POP_OUT     (pop),
        .FREE_HEAD_OUT   (head),
        .FREE_TAIL_OUT   (tail),
        .FREE_NUM_OUT    (num),
        .HEAD_LOAD_OUT   (hld),
        .TAIL_LOAD_OUT   (tld),
        .NUM_LOAD_OUT    (nld),
        .BUILD_CHAIN_OUT (bld)
    );

    initial
    begin
        forever #25 clk = ~clk;
    end

    // pulses are counted, so a doubled or missing one shows up later
    always @(posedge clk)
    begin
        cyc_cnt <= cyc_cnt + 1;
        c_h <= c_h + int'(hld === 1'b1);
        c_t <= c_t + int'(tld === 1'b1);
        c_n <= c_n + int'(nld === 1'b1);
        c_b <= c_b + int'(bld === 1'b1);
        c_p <= c_p + int'(pop === 1'b1);
        if (cyc_cnt == 3000)
        begin
            bad("timeout");
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////
    task automatic bad(input string m);
        $display("BAD %0t %s", $time, m);
        num_errors++;
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e,
                          input string m);
        n_tests++;
        if (g !== e)
            bad(m);
    endtask

    task automatic cmp_p(input logic [14:0] g, input logic [14:0] e,
                         input string m);
        n_tests++;
        if (g !== e)
            bad(m);
    endtask

    task automatic cmp_n(input int g, input int e, input string m);
        n_tests++;
        if (g != e)
            bad(m);
    endtask

    // request held from one edge until the edge that samples ack
    task automatic acc(input logic w, input logic [11:0] idx,
                       input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h000000, d};
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        q_rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        acc(1'b1, idx, d);
    endtask

    task automatic rd(input logic [11:0] idx, input logic [7:0] e);
        acc(1'b0, idx, 8'h00);
        cmp_rd(q_rd, {24'h000000, e}, "read data");
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
    endtask

    function automatic logic [7:0] ix(fgl_rls_t e, logic [2:0] l, int k);
        logic [47:0] v;
        v = {l, e.qm, e.cls, e.src, e.mcast, e.cnt, e.tail, e.head};
        return v[k*8 +: 8];
    endfunction

    task automatic info(input fgl_rls_t e, input logic [2:0] l);
        for (int k = 0; k < 6; k++)
            rd(12'hec8 + 12'(k), ix(e, l, k));
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        for (int i = 'hec1; i <= 'hecd; i++)
            rd(12'(i), 8'h00);
        wr(12'hf00, 8'hff);
        rd(12'hf00, 8'h00);
        wr(12'hec8, 8'hff);
        rd(12'hec8, 8'h00);
        sel <= 4'he;
        wr(12'hec3, 8'hff);
        sel <= 4'h1;
        rd(12'hec3, 8'h00);
        $display("test reset done");
        wr(12'hec3, 8'h5a);
        wr(12'hec4, 8'h3c);
        settle();
        cmp_p(tail, 15'h0000, "tail staged");
        rd(12'hec4, 8'h3c);
        wr(12'hec4, 8'hbc);
        wr(12'hec4, 8'hbc);
        settle();
        cmp_p(tail, 15'h3c5a, "tail value");
        cmp_n(c_t, 1, "tail commits");
        wr(12'hec4, 8'h01);
        wr(12'hec4, 8'h81);
        settle();
        cmp_p(tail, 15'h015a, "tail recommit");
        cmp_n(c_t, 2, "tail commits");
        wr(12'hec1, 8'hff);
        wr(12'hec2, 8'hff);
        wr(12'hec5, 8'h34);
        wr(12'hec6, 8'h92);
        settle();
        cmp_p(head, 15'h7fff, "head value");
        cmp_p(num, 15'h1234, "count value");
        cmp_n(c_n, 1, "count commits");
        cmp_n(c_b, 0, "no build");
        $display("test self link done");
        cmp_n(c_p, 0, "no release while relinking");
        wr(12'hec1, 8'h00);
        wr(12'hec2, 8'h00);
        wr(12'hec2, 8'h80);
        wr(12'hec3, 8'h00);
        wr(12'hec4, 8'h00);
        wr(12'hec4, 8'h80);
        wr(12'hec6, 8'h00);
        wr(12'hec5, 8'h10);
        wr(12'hec6, 8'h80);
        settle();
        cmp_p(head, 15'h0000, "head cleared");
        cmp_p(tail, 15'h0000, "tail cleared");
        cmp_p(num, 15'h0010, "count value");
        cmp_n(c_n, 2, "count commits");
        cmp_n(c_b, 1, "build");
        cmp_n(c_h, 2, "head commits");
        $display("test device link done");
        ent <= e1;
        lvl <= 3'h3;
        wr(12'hec7, 8'h01);
        wr(12'hec7, 8'h01);
        settle();
        cmp_n(c_p, 1, "one pop");
        info(e1, 3'h3);
        ent <= e2;
        lvl <= 3'h2;
        wr(12'hec7, 8'h00);
        wr(12'hec7, 8'h01);
        settle();
        cmp_n(c_p, 2, "second pop");
        info(e2, 3'h2);
        lvl <= 3'h0;
        wr(12'hec7, 8'h00);
        wr(12'hec7, 8'h01);
        settle();
        cmp_n(c_p, 2, "empty pop");
        info(e2, 3'h0);
        rd(12'hec7, 8'h01);
        $display("test release fifo done");
        close_out();
    end
endmodule // testbench

`default_nettype wire
